// ### common/spf_pkg.sv
// shared constants and types for the serial packet framer
`default_nettype none
package spf_pkg;
    localparam int unsigned CLK_HZ = 250000000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned MS_CYCLES = (CLK_HZ / 1000) * TICK_MS;
    localparam int unsigned MS_PER_MIN = 60000;
    localparam int unsigned PROBE_MS = 1000;
    localparam int unsigned BUF_DEPTH = 1024;
    localparam int unsigned PTR_W = 11;
    // register byte addresses
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DELIM_OFS = 8'h04;
    localparam logic [7:0] LEN_OFS = 8'h08;
    localparam logic [7:0] FLUSH_OFS = 8'h0C;
    localparam logic [7:0] INACT_OFS = 8'h10;
    localparam logic [7:0] ALIVE_OFS = 8'h14;
    localparam logic [7:0] STAT_OFS = 8'h18;
    localparam logic [7:0] MASK_OFS = 8'h1C;
    localparam logic [7:0] LEVEL_OFS = 8'h20;
    // reset values
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [15:0] DELIM_RST = 16'h0000;
    localparam logic [10:0] LEN_RST = 11'h000;
    localparam logic [15:0] FLUSH_RST = 16'h0000;
    localparam logic [15:0] INACT_RST = 16'h0000;
    localparam logic [6:0] ALIVE_RST = 7'h07;
    // status bit positions
    localparam int unsigned EV_REL = 0;
    localparam int unsigned EV_INACT = 1;
    localparam int unsigned EV_ALIVE = 2;
    localparam int unsigned EV_OVF = 3;
    localparam int unsigned EV_W = 4;
    typedef enum logic [1:0] {
        SPF_PROC_NONE = 2'h0,
        SPF_PROC_PLUS1 = 2'h1,
        SPF_PROC_PLUS2 = 2'h2,
        SPF_PROC_STRIP = 2'h3
    } spf_proc_e;
    typedef enum logic [1:0] {
        SPF_D_HUNT = 2'b00,
        SPF_D_WAIT2 = 2'b01,
        SPF_D_WAIT1 = 2'b11
    } spf_dst_e;
    typedef enum logic [1:0] {
        SPF_TX_IDLE = 2'b00,
        SPF_TX_SEND = 2'b01
    } spf_tx_e;
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } spf_pkt_s;
endpackage : spf_pkg
`default_nettype wire

// ### hw/spf_framer.sv
// serial packet framer: byte buffer, release logic, connection timers, apb registers
//
// Contract
// - length limit zero: release only on delimiters, full buffer or idle flush
// - length limit 1..1024: release when buffered count reaches the limit
// - two delimiters, each enable plus 8-bit char; pair must be consecutive; off by default
// - with delimiters on, accumulate until buffer full or delimiter seen
// - processing option ignored while first delimiter off; default do nothing
// - do nothing: release at delimiter, delimiters kept in packet
// - delimiter plus one: release after one more character
// - delimiter plus two: release after two more characters
// - idle flush zero: never release for lack of serial data
// - idle flush 1..65535 ms: release after that long without a byte
// - keep-alive probes sent; response timeout 0..99 min, default 7, zero never closes
// - keep-alive 1..99 min: close connection when no response in that time
// - inactivity zero, default: connection stays open forever
// - inactivity 1..65535 ms: close when no data either way for that time
`default_nettype none
module spf_framer #(
    parameter int unsigned MS_CYC = spf_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // serial receiver bytes
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    // network transport
    output spf_pkg::spf_pkt_s pkt_out,
    input wire logic net_act_in,
    input wire logic conn_open_in,
    input wire logic ka_ack_in,
    output logic ka_probe_out,
    output logic conn_close_out,
    // interrupt
    output logic irq_out
);
    import spf_pkg::*;

    function automatic logic [PTR_W-1:0] ptr_sub(input logic [PTR_W-1:0] a, input logic [PTR_W-1:0] b);
        ptr_sub = PTR_W'(a - b);
    endfunction : ptr_sub

    logic [7:0] mem [0:BUF_DEPTH-1];
    logic [3:0] ctrl_reg;
    logic [15:0] delim_reg;
    logic [10:0] len_reg;
    logic [15:0] flush_reg;
    logic [15:0] inact_reg;
    logic [6:0] alive_reg;
    logic [EV_W-1:0] stat_reg;
    logic [EV_W-1:0] mask_reg;
    logic [PTR_W-1:0] wr_reg;
    logic [PTR_W-1:0] rd_reg;
    logic [PTR_W-1:0] start_reg;
    logic q_valid_reg;
    logic [PTR_W-1:0] q_end_reg;
    logic [PTR_W-1:0] q_next_reg;
    logic [PTR_W-1:0] cur_end_reg;
    logic [PTR_W-1:0] cur_next_reg;
    spf_tx_e tx_reg;
    spf_dst_e dst_reg;
    logic prev_c1_reg;
    logic [17:0] ms_cnt_reg;
    logic ms_tick_reg;
    logic [15:0] idle_ms_reg;
    logic [15:0] inact_ms_reg;
    logic [15:0] min_ms_reg;
    logic [6:0] alive_min_reg;
    logic [9:0] probe_ms_reg;

    logic d1_en;
    logic d2_en;
    spf_proc_e proc;
    logic accept;
    logic full;
    logic hit;
    logic [PTR_W-1:0] occ;
    logic [PTR_W-1:0] pend;
    logic [PTR_W-1:0] wr_next;
    logic rel_len;
    logic rel_full;
    logic rel_delim;
    logic rel_idle;
    logic rel;
    logic [PTR_W-1:0] rel_end;
    logic inact_fire;
    logic alive_fire;
    logic apb_wr;
    logic apb_rd_done;
    logic [EV_W-1:0] ev;

    assign d1_en = ctrl_reg[0];
    assign d2_en = ctrl_reg[0] & ctrl_reg[1];
    assign proc = spf_proc_e'(ctrl_reg[3:2]);
    assign occ = ptr_sub(wr_reg, rd_reg);
    assign pend = ptr_sub(wr_reg, start_reg);
    assign full = (occ == PTR_W'(BUF_DEPTH));
    assign accept = rx_valid_in & ~full;
    assign wr_next = accept ? PTR_W'(wr_reg + 1'b1) : wr_reg;
    // single char, or second char right after the first
    assign hit = accept & d1_en & (d2_en ? (prev_c1_reg & (rx_data_in == delim_reg[15:8]))
                                         : (rx_data_in == delim_reg[7:0]));
    assign rel_len = accept & (len_reg != 11'h000) & (ptr_sub(wr_next, start_reg) == PTR_W'(len_reg));
    assign rel_full = accept & (ptr_sub(wr_next, rd_reg) == PTR_W'(BUF_DEPTH));
    always_comb begin
        rel_delim = 1'b0;
        if (accept && d1_en) begin
            case (dst_reg)
                SPF_D_HUNT: rel_delim = hit && (proc == SPF_PROC_NONE || proc == SPF_PROC_STRIP);
                SPF_D_WAIT1: rel_delim = 1'b1;
                default: rel_delim = 1'b0;
            endcase
        end
    end
    assign rel_idle = ~accept & (flush_reg != 16'h0000) & (pend != '0) & (idle_ms_reg >= flush_reg);
    assign rel = rel_len | rel_full | rel_delim | rel_idle;
    assign rel_end = (hit && dst_reg == SPF_D_HUNT && proc == SPF_PROC_STRIP)
                   ? ptr_sub(wr_next, d2_en ? PTR_W'(2) : PTR_W'(1)) : wr_next;
    assign apb_wr = psel_in & penable_in & pwrite_in;
    assign apb_rd_done = psel_in & penable_in & ~pwrite_in;

    // configuration registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= CTRL_RST;
            delim_reg <= DELIM_RST;
            len_reg <= LEN_RST;
            flush_reg <= FLUSH_RST;
            inact_reg <= INACT_RST;
            alive_reg <= ALIVE_RST;
            mask_reg <= '0;
        end else if (apb_wr) begin
            case (paddr_in)
                CTRL_OFS: ctrl_reg <= pwdata_in[3:0];
                DELIM_OFS: delim_reg <= pwdata_in[15:0];
                LEN_OFS: len_reg <= (pwdata_in > 32'h0000_0400) ? 11'h400 : pwdata_in[10:0];
                FLUSH_OFS: flush_reg <= pwdata_in[15:0];
                INACT_OFS: inact_reg <= pwdata_in[15:0];
                ALIVE_OFS: alive_reg <= (pwdata_in > 32'h0000_0063) ? 7'h63 : pwdata_in[6:0];
                MASK_OFS: mask_reg <= pwdata_in[EV_W-1:0];
                default: ;
            endcase
        end
    end

    // apb answer: data captured in setup, zero wait states
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= 1'b1;
            if (psel_in && !penable_in) begin
                pslverr_out <= 1'b0;
                case (paddr_in)
                    CTRL_OFS: prdata_out <= {28'h0, ctrl_reg};
                    DELIM_OFS: prdata_out <= {16'h0, delim_reg};
                    LEN_OFS: prdata_out <= {21'h0, len_reg};
                    FLUSH_OFS: prdata_out <= {16'h0, flush_reg};
                    INACT_OFS: prdata_out <= {16'h0, inact_reg};
                    ALIVE_OFS: prdata_out <= {25'h0, alive_reg};
                    STAT_OFS: prdata_out <= {28'h0, stat_reg | ev};
                    MASK_OFS: prdata_out <= {28'h0, mask_reg};
                    LEVEL_OFS: prdata_out <= {5'h0, pend, 5'h0, occ};
                    default: begin
                        prdata_out <= 32'h0000_0000;
                        pslverr_out <= 1'b1;
                    end
                endcase
            end
        end
    end

    // sticky events; read clears, a new event in that cycle survives
    assign ev = {(accept && q_valid_reg && rel) || (rx_valid_in && full), alive_fire, inact_fire, rel};
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stat_reg <= '0;
            irq_out <= 1'b0;
        end else begin
            if (apb_rd_done && paddr_in == STAT_OFS) begin
                stat_reg <= ev;
            end else begin
                stat_reg <= stat_reg | ev;
            end
            irq_out <= |((stat_reg | ev) & mask_reg);
        end
    end

    // byte store and release bookkeeping
    always_ff @(posedge clk_in) begin
        if (accept) begin
            mem[wr_reg[PTR_W-2:0]] <= rx_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_reg <= '0;
            start_reg <= '0;
            q_valid_reg <= 1'b0;
            q_end_reg <= '0;
            q_next_reg <= '0;
            prev_c1_reg <= 1'b0;
            dst_reg <= SPF_D_HUNT;
        end else begin
            wr_reg <= wr_next;
            if (rel) begin
                start_reg <= wr_next;
                q_valid_reg <= 1'b1;
                q_end_reg <= rel_end;
                q_next_reg <= wr_next;
            end else if (tx_reg == SPF_TX_IDLE) begin
                q_valid_reg <= 1'b0;
            end
            if (accept) begin
                prev_c1_reg <= ~rel & (rx_data_in == delim_reg[7:0]);
            end else if (rel) begin
                prev_c1_reg <= 1'b0;
            end
            if (rel || !d1_en) begin
                dst_reg <= SPF_D_HUNT;
            end else if (accept) begin
                case (dst_reg)
                    SPF_D_HUNT: begin
                        if (hit && proc == SPF_PROC_PLUS1) dst_reg <= SPF_D_WAIT1;
                        if (hit && proc == SPF_PROC_PLUS2) dst_reg <= SPF_D_WAIT2;
                    end
                    SPF_D_WAIT2: dst_reg <= SPF_D_WAIT1;
                    default: dst_reg <= SPF_D_HUNT;
                endcase
            end
        end
    end

    // packet drain toward the transport, one byte per cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_reg <= SPF_TX_IDLE;
            rd_reg <= '0;
            cur_end_reg <= '0;
            cur_next_reg <= '0;
            pkt_out <= '0;
        end else begin
            pkt_out.valid <= 1'b0;
            pkt_out.last <= 1'b0;
            case (tx_reg)
                SPF_TX_IDLE: begin
                    if (q_valid_reg) begin
                        cur_end_reg <= q_end_reg;
                        cur_next_reg <= q_next_reg;
                        tx_reg <= SPF_TX_SEND;
                    end
                end
                SPF_TX_SEND: begin
                    if (rd_reg == cur_end_reg) begin
                        rd_reg <= cur_next_reg;
                        tx_reg <= SPF_TX_IDLE;
                    end else begin
                        pkt_out.valid <= 1'b1;
                        pkt_out.data <= mem[rd_reg[PTR_W-2:0]];
                        pkt_out.last <= (PTR_W'(rd_reg + 1'b1) == cur_end_reg);
                        rd_reg <= PTR_W'(rd_reg + 1'b1);
                    end
                end
                default: tx_reg <= SPF_TX_IDLE;
            endcase
        end
    end

    // millisecond tick and the timers it drives
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ms_cnt_reg <= '0;
            ms_tick_reg <= 1'b0;
        end else begin
            ms_tick_reg <= (ms_cnt_reg == 18'(MS_CYC - 1));
            ms_cnt_reg <= (ms_cnt_reg == 18'(MS_CYC - 1)) ? 18'h00000 : 18'(ms_cnt_reg + 1'b1);
        end
    end
    assign inact_fire = conn_open_in & ~conn_close_out & (inact_reg != 16'h0000)
                      & (inact_ms_reg >= inact_reg);
    assign alive_fire = conn_open_in & ~conn_close_out & (alive_reg != 7'h00)
                      & (alive_min_reg >= alive_reg);
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            idle_ms_reg <= 16'h0000;
            inact_ms_reg <= 16'h0000;
        end else begin
            // a release restarts the count, or the tick in that cycle leaves a stale value
            if (accept || pend == '0 || rel) begin
                idle_ms_reg <= 16'h0000;
            end else if (ms_tick_reg && idle_ms_reg != 16'hFFFF) begin
                idle_ms_reg <= 16'(idle_ms_reg + 1'b1);
            end
            if (rx_valid_in || pkt_out.valid || net_act_in || !conn_open_in || inact_fire) begin
                inact_ms_reg <= 16'h0000;
            end else if (ms_tick_reg && inact_ms_reg != 16'hFFFF) begin
                inact_ms_reg <= 16'(inact_ms_reg + 1'b1);
            end
        end
    end

    // keep-alive probing and response supervision
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            min_ms_reg <= 16'h0000;
            alive_min_reg <= 7'h00;
            probe_ms_reg <= 10'h000;
            ka_probe_out <= 1'b0;
            conn_close_out <= 1'b0;
        end else begin
            ka_probe_out <= 1'b0;
            conn_close_out <= inact_fire | alive_fire;
            if (!conn_open_in) begin
                probe_ms_reg <= 10'h000;
            end else if (ms_tick_reg) begin
                probe_ms_reg <= (probe_ms_reg == 10'(PROBE_MS - 1)) ? 10'h000 : 10'(probe_ms_reg + 1'b1);
                ka_probe_out <= (probe_ms_reg == 10'(PROBE_MS - 1));
            end
            if (ka_ack_in || !conn_open_in || alive_fire) begin
                min_ms_reg <= 16'h0000;
                alive_min_reg <= 7'h00;
            end else if (ms_tick_reg) begin
                if (min_ms_reg == 16'(MS_PER_MIN - 1)) begin
                    min_ms_reg <= 16'h0000;
                    if (alive_min_reg != 7'h7F) alive_min_reg <= 7'(alive_min_reg + 1'b1);
                end else begin
                    min_ms_reg <= 16'(min_ms_reg + 1'b1);
                end
            end
        end
    end

    // checks
    sequence s_delim_hunt;
        hit && dst_reg == SPF_D_HUNT;
    endsequence
    sequence s_plus2_hit;
        s_delim_hunt and (proc == SPF_PROC_PLUS2 && !rel);
    endsequence
    len_release_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rel_len |=> q_valid_reg && start_reg == wr_reg) else $error("length limit did not release");
    len_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (len_reg == 11'h000) |-> !rel_len) else $error("length release with limit zero");
    delim_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (s_delim_hunt and proc == SPF_PROC_NONE) |-> rel && rel_end == wr_next) else $error("delimiter not kept");
    plus_one_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (s_delim_hunt and (proc == SPF_PROC_PLUS1 && !rel)) |=> dst_reg == SPF_D_WAIT1 && $stable(start_reg))
        else $error("plus one wait missing");
    plus_two_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_plus2_hit ##1 (accept && d1_en && proc == SPF_PROC_PLUS2) |-> !rel_delim ##1 dst_reg == SPF_D_WAIT1)
        else $error("plus two released early");
    strip_end_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (s_delim_hunt and proc == SPF_PROC_STRIP) |-> rel_end == ptr_sub(wr_next, d2_en ? PTR_W'(2) : PTR_W'(1)))
        else $error("delimiter not stripped");
    idle_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (flush_reg == 16'h0000) |-> !rel_idle) else $error("idle release while disabled");
    idle_release_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rel_idle |=> q_valid_reg && pend == '0 && idle_ms_reg == 16'h0000) else $error("idle flush failed");
    inact_close_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        inact_fire |=> conn_close_out && inact_ms_reg == 16'h0000) else $error("inactivity close missing");
    alive_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (alive_reg == 7'h00) |-> !alive_fire) else $error("keep-alive close while disabled");
    alive_restart_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ka_ack_in |=> alive_min_reg == 7'h00 && min_ms_reg == 16'h0000) else $error("keep-alive answer ignored");
endmodule : spf_framer
`default_nettype wire

// ### bench/spf_net_model.sv
// network transport model: collects released packets and answers keep-alive probes
`default_nettype none
module spf_net_model
    import spf_pkg::*;
#(
    parameter int unsigned ACK_DLY = 3
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // framer side
    input wire spf_pkg::spf_pkt_s pkt_in,
    input wire logic ka_probe_in,
    input wire logic conn_close_in,
    // bench control
    input wire logic ack_en_in,
    // transport outputs
    output logic net_act_out,
    output logic conn_open_out,
    output logic ka_ack_out
);
    logic [7:0] got[$];
    int n_pkt;
    int n_close;
    int n_probe;
    int ack_cnt;
    always @(posedge clk_in) begin
        conn_open_out <= rst_n_in;
        net_act_out <= rst_n_in & pkt_in.valid & pkt_in.last;
        ka_ack_out <= 1'b0;
        if (!rst_n_in) begin
            got.delete();
            n_pkt <= 0;
            n_close <= 0;
            n_probe <= 0;
            ack_cnt <= 0;
        end else begin
            if (pkt_in.valid) begin
                got.push_back(pkt_in.data);
            end
            if (pkt_in.valid && pkt_in.last) begin
                n_pkt <= n_pkt + 1;
            end
            if (conn_close_in) begin
                n_close <= n_close + 1;
            end
            // probe answered after a delay only when the bench allows it
            if (ka_probe_in) begin
                n_probe <= n_probe + 1;
                ack_cnt <= ack_en_in ? int'(ACK_DLY) : 0;
            end else if (ack_cnt != 0) begin
                ack_cnt <= ack_cnt - 1;
                ka_ack_out <= (ack_cnt == 1);
            end
        end
    end
endmodule : spf_net_model
`default_nettype wire

// ### bench/tb.sv
// self-checking testbench of the serial packet framer
`default_nettype none
module tb
    import spf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] D1 = 8'hA5;
    localparam logic [7:0] D2 = 8'hC3;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    spf_pkt_s pkt;
    logic net_act, conn_open, ka_ack, ka_probe, conn_close, irq;
    logic ack_en = 1'b1;
    logic [31:0] seed = 32'h19F925DD;
    logic [31:0] rd_v;
    logic err_v;
    logic [7:0] s[$];
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int el, nc;
    always #2 clk = ~clk;
    spf_framer #(.MS_CYC(1)) dut_u (.clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .rx_valid_in(rx_valid), .rx_data_in(rx_data), .pkt_out(pkt),
        .net_act_in(net_act), .conn_open_in(conn_open), .ka_ack_in(ka_ack), .ka_probe_out(ka_probe),
        .conn_close_out(conn_close), .irq_out(irq));
    spf_net_model net_u (.clk_in(clk), .rst_n_in(rst_n), .pkt_in(pkt), .ka_probe_in(ka_probe),
        .conn_close_in(conn_close), .ack_en_in(ack_en), .net_act_out(net_act), .conn_open_out(conn_open),
        .ka_ack_out(ka_ack));
    function logic [7:0] rb();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {1'b0, seed[6:0]};
    endfunction : rb
    // bytes expected in the first packet once the terminator ends at index k
    function automatic int exp_cnt(input int mode, input int k, input int nd);
        return (mode == 3) ? k + 1 - nd : k + 1 + mode;
    endfunction : exp_cnt
    task end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task reset_dut();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : reset_dut
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task send();
        foreach (s[i]) begin
            rx_valid <= 1'b1;
            rx_data <= s[i];
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        rx_data <= ~s[s.size() - 1];
        repeat (30) @(posedge clk);
    endtask : send
    task check_pkt(input int cnt, input int npk);
        chk(32'(net_u.got.size()), 32'(cnt));
        chk(32'(net_u.n_pkt), 32'(npk));
        for (int i = 0; i < cnt; i++) chk(32'(net_u.got[i]), 32'(s[i]));
    endtask : check_pkt
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        reset_dut();
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd_v, 32'(CTRL_RST));
        apb(1'b0, ALIVE_OFS, 32'h0);
        chk(rd_v, 32'(ALIVE_RST));
        apb(1'b0, 8'h24, 32'h0);
        chk({rd_v[30:0], err_v}, 32'h1);
        apb(1'b1, ALIVE_OFS, 32'd200);
        apb(1'b0, ALIVE_OFS, 32'h0);
        chk(rd_v, 32'd99);
        apb(1'b1, LEN_OFS, 32'd2000);
        apb(1'b0, LEN_OFS, 32'h0);
        chk(rd_v, 32'd1024);
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 2; p++) begin
                reset_dut();
                apb(1'b1, DELIM_OFS, {16'h0, D2, D1});
                apb(1'b1, CTRL_OFS, {28'h0, 2'(m), 1'(p), 1'b1});
                if (p != 0) s = {rb(), D1, rb(), D1, D2, rb(), rb(), rb()};
                else s = {rb(), rb(), D1, rb(), rb(), rb(), rb()};
                send();
                check_pkt(exp_cnt(m, p ? 4 : 2, p + 1), 1);
            end
        end
        reset_dut();
        apb(1'b1, LEN_OFS, 32'd3);
        s = {rb(), rb(), rb(), rb(), rb(), rb(), rb()};
        send();
        check_pkt(6, 2);
        reset_dut();
        apb(1'b1, DELIM_OFS, {24'h0, D1});
        apb(1'b1, CTRL_OFS, 32'h1);
        s.delete();
        repeat (1024) s.push_back(rb());
        send();
        // the full buffer is released only at its last byte and drains one byte per cycle
        repeat (1030) @(posedge clk);
        check_pkt(1024, 1);
        for (int f = 0; f < 2; f++) begin
            reset_dut();
            apb(1'b1, DELIM_OFS, {24'h0, D1});
            apb(1'b1, CTRL_OFS, 32'hC);
            apb(1'b1, FLUSH_OFS, 32'(5 * f));
            s = {rb(), D1, rb()};
            send();
            check_pkt(3 * f, f);
        end
        reset_dut();
        apb(1'b1, MASK_OFS, 32'h2);
        apb(1'b1, INACT_OFS, 32'd4);
        repeat (20) @(posedge clk);
        chk(32'(net_u.n_close != 0), 32'h1);
        chk(32'(irq), 32'h1);
        apb(1'b1, INACT_OFS, 32'h0);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(32'(rd_v[EV_INACT]), 32'h1);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd_v, 32'h0);
        chk(32'(irq), 32'h0);
        nc = net_u.n_close;
        repeat (50) @(posedge clk);
        chk(32'(net_u.n_close), 32'(nc));
        ack_en <= 1'b0;
        reset_dut();
        apb(1'b1, ALIVE_OFS, 32'd1);
        for (el = 0; el < 62000 && net_u.n_close == 0; el++) @(posedge clk);
        chk(32'(el > 59000 && el < 61000), 32'h1);
        chk(32'(net_u.n_probe > 50), 32'h1);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
